// File: inc/can_mbx_params.svh
`ifndef CAN_MBX_PARAMS_SVH
`define CAN_MBX_PARAMS_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define CMF_TX_STATUS_OFS 8'h08
`define CMF_RXQ0_STATUS_OFS 8'h0C
`define CMF_RXQ1_STATUS_OFS 8'h10
`define CMF_CTRL_OFS 8'h40
// ----------------------------------------
// Reset values
// ----------------------------------------
`define CMF_TX_STATUS_RST 32'h1C00_0000
`define CMF_RXQ_STATUS_RST 32'h0000_0000
// ----------------------------------------
// Transmit status fields
// ----------------------------------------
`define CMF_TX_LOW_LSB 29
`define CMF_TX_VACANT_LSB 26
`define CMF_TX_CODE_LSB 24
`define CMF_TX_SLOT_STRIDE 8
`define CMF_TX_CANCEL_BIT 7
`define CMF_TX_FAULT_BIT 3
`define CMF_TX_LOST_BIT 2
`define CMF_TX_SUCCESS_BIT 1
`define CMF_TX_DONE_BIT 0
// ----------------------------------------
// Receive queue status fields
// ----------------------------------------
`define CMF_RX_RELEASE_BIT 5
`define CMF_RX_OVERRUN_BIT 4
`define CMF_RX_FULL_BIT 3
`define CMF_RX_COUNT_LSB 0
`define CMF_RX_DEPTH 2'h3
// ----------------------------------------
// Control register fields
// ----------------------------------------
`define CMF_CTRL_LOCK_BIT 0
`define CMF_CTRL_PIRQ0_BIT 1
`define CMF_CTRL_PIRQ1_BIT 2
`define CMF_CTRL_ORDER_BIT 3
`endif

// File: inc/can_mbx_pkg.sv
package can_mbx_pkg;
    // Outcome of one transmission attempt
    typedef enum logic [1:0] {
        TX_OUT_SUCCESS,
        TX_OUT_BUS_FAULT,
        TX_OUT_LOST_ARB
    } tx_outcome_e;

    // Attempt report from the protocol engine
    typedef struct packed {
        logic valid;
        logic [1:0] slot;
        tx_outcome_e outcome;
    } tx_attempt_s;

    // Software write actions on one receive queue
    typedef struct packed {
        logic release_req;
        logic clr_overrun;
        logic clr_full;
    } rxq_write_s;

    // Visible state of one receive queue
    typedef struct packed {
        logic release_busy;
        logic overrun;
        logic full;
        logic [1:0] count;
    } rxq_status_s;
endpackage : can_mbx_pkg

// File: design/rx_queue_status.sv
`timescale 1ns/1ps
`include "can_mbx_params.svh"
module rx_queue_status (
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic clk_en_i,
    input wire logic store_i,
    input wire logic lock_i,
    input wire logic irq_en_i,
    input wire can_mbx_pkg::rxq_write_s wr_i,
    output can_mbx_pkg::rxq_status_s status_o,
    output logic release_o,
    output logic overwrite_o,
    output logic irq_o
);
    can_mbx_pkg::rxq_status_s st_q, st_d;
    logic irq_q, irq_d;
    logic [1:0] eff;

    // Next queue state from stores, releases and clears
    always_comb begin
        st_d = st_q;
        eff = st_q.count - {1'b0, st_q.release_busy};
        st_d.count = eff;
        st_d.release_busy = 1'b0;
        if (!st_q.release_busy && wr_i.release_req && st_q.count != 2'h0) begin
            st_d.release_busy = 1'b1;
        end
        if (wr_i.clr_overrun) st_d.overrun = 1'b0;
        if (wr_i.clr_full) st_d.full = 1'b0;
        if (store_i) begin
            if (eff != `CMF_RX_DEPTH) st_d.count = eff + 2'h1;
            else st_d.overrun = 1'b1;
        end
        if (st_d.count == `CMF_RX_DEPTH) st_d.full = 1'b1;
        irq_d = irq_en_i && st_d.count != 2'h0;
    end

    // State registers
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            st_q <= '0;
            irq_q <= 1'b0;
        end else if (clk_en_i) begin
            st_q <= st_d;
            irq_q <= irq_d;
        end
    end

    assign status_o = st_q;
    assign irq_o = irq_q;
    assign release_o = st_q.release_busy;
    // Full queue: lock discards the new message, else it replaces the last
    assign overwrite_o = store_i && eff == `CMF_RX_DEPTH && !lock_i;

    a_release_drops_count: assert property (@(posedge clk_sys_i) disable iff (srst_i || !clk_en_i)
        (st_q.release_busy && !store_i) |=> st_q.count == $past(st_q.count) - 2'h1)
        else $error("release did not drop count");
    a_empty_release_idle: assert property (@(posedge clk_sys_i) disable iff (srst_i || !clk_en_i)
        (wr_i.release_req && st_q.count == 2'h0) |=> !st_q.release_busy)
        else $error("release on empty queue took effect");
    a_overrun_on_full: assert property (@(posedge clk_sys_i) disable iff (srst_i || !clk_en_i)
        (store_i && st_q.count == 2'h3 && !st_q.release_busy) |=> st_q.overrun && st_q.count == 2'h3)
        else $error("overrun not flagged");
    a_irq_follows_count: assert property (@(posedge clk_sys_i) disable iff (srst_i || !clk_en_i)
        (irq_en_i && st_q.count != 2'h0 && !st_q.release_busy && !$past(wr_i.release_req)) |=> irq_o)
        else $error("pending irq missing");
endmodule : rx_queue_status

// File: design/can_mailbox_fifo_status.sv
// Behaviour
// - Lowest-ranked pending mailbox flagged when several pending
// - Lowest flags zero with single pending mailbox
// - Vacant flag set while no request outstanding
// - Code gives next free mailbox index
// - All pending: code gives lowest-priority mailbox
// - Cancel bit cleared once mailbox empty
// - Cancel on idle mailbox has no effect
// - Bus-fault flag set on failed attempt
// - Lost-arbitration flag set on lost attempt
// - Success flag updated after every attempt
// - Done flag set when transmit or abort finishes
// - Done cleared by write-one or new request
// - Clearing done clears success, lost, fault
// - Transmit status resets to 0x1C000000
// - Release ignored when queue is empty
// - Release bit self-clears after release
// - Overrun set on accepted message while full
// - Full flag set at three, write-one clears
// - Count up on store, down on release
// - Second queue register identical at 0x10
// - Reserved bits read zero
// - Full queue: overwrite unless locked, else discard
// - Pending irq when count nonzero and enabled
`timescale 1ns/1ps
`include "can_mbx_params.svh"
module can_mailbox_fifo_status #(
    parameter int ID_W = 29
) (
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic clk_en_i,
    input wire logic [7:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic [2:0] tx_send_request_i,
    input wire logic [2:0] tx_active_i,
    input wire can_mbx_pkg::tx_attempt_s tx_attempt_i,
    input wire logic [2:0][ID_W-1:0] tx_slot_id_i,
    output logic [2:0] tx_pending_o,
    output logic [2:0] tx_cancel_o,
    output logic [1:0] tx_next_slot_o,
    input wire logic [1:0] rx_store_i,
    output logic [1:0] rx_release_o,
    output logic [1:0] rx_overwrite_o,
    output logic [1:0] rx_pending_irq_o
);
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // Index of the lowest set bit of a three-bit vector
    function automatic logic [1:0] first_set(input logic [2:0] v);
        logic [1:0] r;
        r = 2'h0;
        if (v[0]) r = 2'h0;
        else if (v[1]) r = 2'h1;
        else if (v[2]) r = 2'h2;
        return r;
    endfunction : first_set

    // Offset match on a word-aligned byte address
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        return a == ofs;
    endfunction : hit

    // ----------------------------------------
    // Avalon slave: one wait state per access
    // ----------------------------------------
    logic ack_q, ack_d;
    logic [31:0] rdata_q, rdata_d;
    logic [31:0] rd_word;
    logic [31:0] wmask;
    logic [31:0] wbits;
    logic wr_en;
    logic wr_tx, wr_ctrl;
    logic [1:0] wr_rxq;

    // Byte lanes to bit mask
    always_comb begin
        for (int b = 0; b < 4; b++) begin
            wmask[b*8 +: 8] = {8{avs_byteenable_i[b]}};
        end
    end

    assign wbits = avs_writedata_i & wmask;
    assign wr_en = avs_write_i && ack_q && clk_en_i;
    assign wr_tx = wr_en && hit(avs_address_i, `CMF_TX_STATUS_OFS);
    assign wr_rxq[0] = wr_en && hit(avs_address_i, `CMF_RXQ0_STATUS_OFS);
    assign wr_rxq[1] = wr_en && hit(avs_address_i, `CMF_RXQ1_STATUS_OFS);
    assign wr_ctrl = wr_en && hit(avs_address_i, `CMF_CTRL_OFS);
    assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !(ack_q && clk_en_i);
    assign avs_readdata_o = rdata_q;

    // Acknowledge and read capture
    always_comb begin
        ack_d = (avs_read_i || avs_write_i) && !ack_q;
        rdata_d = rdata_q;
        if (avs_read_i && !ack_q) begin
            rdata_d = rd_word;
        end
    end

    // Bus registers
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            ack_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else if (clk_en_i) begin
            ack_q <= ack_d;
            rdata_q <= rdata_d;
        end
    end

    // ----------------------------------------
    // Control register
    // ----------------------------------------
    logic [3:0] ctrl_q, ctrl_d;

    // Lock, irq enables and priority mode
    always_comb begin
        ctrl_d = ctrl_q;
        if (wr_ctrl) begin
            ctrl_d = (ctrl_q & ~wmask[3:0]) | wbits[3:0];
        end
    end

    // Control storage
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            ctrl_q <= 4'h0;
        end else if (clk_en_i) begin
            ctrl_q <= ctrl_d;
        end
    end

    // ----------------------------------------
    // Transmit mailbox state
    // ----------------------------------------
    logic [2:0] pending_q, pending_d;
    logic [2:0] cancel_q, cancel_d;
    logic [2:0] fault_q, fault_d;
    logic [2:0] lost_q, lost_d;
    logic [2:0] success_q, success_d;
    logic [2:0] done_q, done_d;
    logic [2:0][2:0] older_q, older_d;
    logic [2:0] low;
    logic [2:0] vacant;
    logic [1:0] code;
    logic order_mode;
    logic hit_slot;

    assign order_mode = ctrl_q[`CMF_CTRL_ORDER_BIT];

    // Mailbox flags from requests, attempts, aborts and writes
    always_comb begin
        pending_d = pending_q;
        cancel_d = cancel_q;
        fault_d = fault_q;
        lost_d = lost_q;
        success_d = success_q;
        done_d = done_q;
        older_d = older_q;
        hit_slot = 1'b0;
        for (int i = 0; i < 3; i++) begin
            // Write-one clears status, write-one to cancel requests an abort; zeros leave flags alone
            if (wr_tx) begin
                if (wbits[i*`CMF_TX_SLOT_STRIDE + `CMF_TX_FAULT_BIT]) fault_d[i] = 1'b0;
                if (wbits[i*`CMF_TX_SLOT_STRIDE + `CMF_TX_LOST_BIT]) lost_d[i] = 1'b0;
                if (wbits[i*`CMF_TX_SLOT_STRIDE + `CMF_TX_SUCCESS_BIT]) success_d[i] = 1'b0;
                if (wbits[i*`CMF_TX_SLOT_STRIDE + `CMF_TX_DONE_BIT]) begin
                    done_d[i] = 1'b0;
                    fault_d[i] = 1'b0;
                    lost_d[i] = 1'b0;
                    success_d[i] = 1'b0;
                end
                if (wbits[i*`CMF_TX_SLOT_STRIDE + `CMF_TX_CANCEL_BIT] && pending_q[i]) begin
                    cancel_d[i] = 1'b1;
                end
            end
            // New request: pending, status cleared, youngest in order
            if (tx_send_request_i[i]) begin
                pending_d[i] = 1'b1;
                done_d[i] = 1'b0;
                fault_d[i] = 1'b0;
                lost_d[i] = 1'b0;
                success_d[i] = 1'b0;
                cancel_d[i] = 1'b0;
                for (int j = 0; j < 3; j++) begin
                    if (j != i) begin
                        older_d[j][i] = 1'b1;
                        older_d[i][j] = 1'b0;
                    end
                end
            end
            hit_slot = tx_attempt_i.valid && tx_attempt_i.slot == 2'(i) && pending_q[i];
            if (hit_slot) begin
                // Attempt result; hardware set wins over a same-cycle clear
                success_d[i] = tx_attempt_i.outcome == can_mbx_pkg::TX_OUT_SUCCESS;
                fault_d[i] = tx_attempt_i.outcome == can_mbx_pkg::TX_OUT_BUS_FAULT;
                lost_d[i] = tx_attempt_i.outcome == can_mbx_pkg::TX_OUT_LOST_ARB;
                if (success_d[i] || cancel_q[i]) begin
                    pending_d[i] = 1'b0;
                    done_d[i] = 1'b1;
                end
            end else if (cancel_q[i] && pending_q[i] && !tx_active_i[i]) begin
                // Abort of an idle pending mailbox finishes at once
                pending_d[i] = 1'b0;
                done_d[i] = 1'b1;
            end
            if (!pending_d[i]) begin
                cancel_d[i] = 1'b0;
            end
        end
    end

    // Mailbox registers
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            pending_q <= 3'h0;
            cancel_q <= 3'h0;
            fault_q <= 3'h0;
            lost_q <= 3'h0;
            success_q <= 3'h0;
            done_q <= 3'h0;
            older_q <= '0;
        end else if (clk_en_i) begin
            pending_q <= pending_d;
            cancel_q <= cancel_d;
            fault_q <= fault_d;
            lost_q <= lost_d;
            success_q <= success_d;
            done_q <= done_d;
            older_q <= older_d;
        end
    end

    // ----------------------------------------
    // Priority ranking and mailbox code
    // ----------------------------------------
    // True when mailbox a ranks below mailbox b
    function automatic logic ranks_below(
        input int a,
        input int b,
        input logic mode,
        input logic [2:0][2:0] older,
        input logic [2:0][ID_W-1:0] ids
    );
        logic r;
        r = 1'b0;
        if (mode) r = older[b][a];
        else if (ids[a] != ids[b]) r = ids[a] > ids[b];
        else r = a > b;
        return r;
    endfunction : ranks_below

    // Lowest-priority flag per mailbox
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            low[i] = pending_q[i] && ($countones(pending_q) > 1);
            for (int j = 0; j < 3; j++) begin
                if (j != i && pending_q[j] && !ranks_below(i, j, order_mode, older_q, tx_slot_id_i)) begin
                    low[i] = 1'b0;
                end
            end
        end
    end

    assign vacant = ~pending_q;

    // Next free mailbox, or the lowest one when all are pending
    always_comb begin
        if (vacant != 3'h0) code = first_set(vacant);
        else code = first_set(low);
    end

    assign tx_pending_o = pending_q;
    assign tx_cancel_o = cancel_q;
    assign tx_next_slot_o = code;

    // ----------------------------------------
    // Receive queues
    // ----------------------------------------
    can_mbx_pkg::rxq_write_s [1:0] rxq_wr;
    can_mbx_pkg::rxq_status_s [1:0] rxq_st;
    logic [1:0] pirq_en;

    assign pirq_en = {ctrl_q[`CMF_CTRL_PIRQ1_BIT], ctrl_q[`CMF_CTRL_PIRQ0_BIT]};

    generate
        for (genvar q = 0; q < 2; q++) begin : g_rxq
            // Release request and write-one clears for this queue
            assign rxq_wr[q].release_req = wr_rxq[q] && wbits[`CMF_RX_RELEASE_BIT];
            assign rxq_wr[q].clr_overrun = wr_rxq[q] && wbits[`CMF_RX_OVERRUN_BIT];
            assign rxq_wr[q].clr_full = wr_rxq[q] && wbits[`CMF_RX_FULL_BIT];

            rx_queue_status u_rxq (
                .clk_sys_i(clk_sys_i),
                .srst_i(srst_i),
                .clk_en_i(clk_en_i),
                .store_i(rx_store_i[q]),
                .lock_i(ctrl_q[`CMF_CTRL_LOCK_BIT]),
                .irq_en_i(pirq_en[q]),
                .wr_i(rxq_wr[q]),
                .status_o(rxq_st[q]),
                .release_o(rx_release_o[q]),
                .overwrite_o(rx_overwrite_o[q]),
                .irq_o(rx_pending_irq_o[q])
            );
        end
    endgenerate

    // ----------------------------------------
    // Read-back words
    // ----------------------------------------
    logic [31:0] tx_word;
    logic [1:0][31:0] rxq_word;

    // Assemble status words; unlisted bits stay zero
    always_comb begin
        tx_word = 32'h0000_0000;
        tx_word[`CMF_TX_LOW_LSB +: 3] = low;
        tx_word[`CMF_TX_VACANT_LSB +: 3] = vacant;
        tx_word[`CMF_TX_CODE_LSB +: 2] = code;
        for (int i = 0; i < 3; i++) begin
            tx_word[i*`CMF_TX_SLOT_STRIDE + `CMF_TX_CANCEL_BIT] = cancel_q[i];
            tx_word[i*`CMF_TX_SLOT_STRIDE + `CMF_TX_FAULT_BIT] = fault_q[i];
            tx_word[i*`CMF_TX_SLOT_STRIDE + `CMF_TX_LOST_BIT] = lost_q[i];
            tx_word[i*`CMF_TX_SLOT_STRIDE + `CMF_TX_SUCCESS_BIT] = success_q[i];
            tx_word[i*`CMF_TX_SLOT_STRIDE + `CMF_TX_DONE_BIT] = done_q[i];
        end
        for (int q = 0; q < 2; q++) begin
            rxq_word[q] = 32'h0000_0000;
            rxq_word[q][`CMF_RX_RELEASE_BIT] = rxq_st[q].release_busy;
            rxq_word[q][`CMF_RX_OVERRUN_BIT] = rxq_st[q].overrun;
            rxq_word[q][`CMF_RX_FULL_BIT] = rxq_st[q].full;
            rxq_word[q][`CMF_RX_COUNT_LSB +: 2] = rxq_st[q].count;
        end
    end

    // Address decode for reads; unmapped reads zero
    always_comb begin
        rd_word = 32'h0000_0000;
        if (hit(avs_address_i, `CMF_TX_STATUS_OFS)) rd_word = tx_word;
        else if (hit(avs_address_i, `CMF_RXQ0_STATUS_OFS)) rd_word = rxq_word[0];
        else if (hit(avs_address_i, `CMF_RXQ1_STATUS_OFS)) rd_word = rxq_word[1];
        else if (hit(avs_address_i, `CMF_CTRL_OFS)) rd_word = {28'h000_0000, ctrl_q};
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_reset_word_value: assert property (@(posedge clk_sys_i)
        srst_i |=> tx_word == `CMF_TX_STATUS_RST)
        else $error("transmit status reset value wrong");
    a_single_no_low: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        ($countones(pending_q) <= 1) |-> low == 3'h0)
        else $error("lowest flag with single pending");
    a_all_pending_code: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        (pending_q == 3'h7) |-> low[code] && $countones(low) == 1)
        else $error("code not at lowest mailbox");
    a_free_code_vacant: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        (pending_q != 3'h7) |-> vacant[code])
        else $error("code not at free mailbox");
    a_request_clears_vacant: assert property (@(posedge clk_sys_i) disable iff (srst_i || !clk_en_i)
        tx_send_request_i[0] |=> !vacant[0] && !done_q[0])
        else $error("request did not occupy mailbox");
    a_cancel_idle_ignored: assert property (@(posedge clk_sys_i) disable iff (srst_i || !clk_en_i)
        (wr_tx && wbits[2*`CMF_TX_SLOT_STRIDE + `CMF_TX_CANCEL_BIT] && !pending_q[2]
            && !tx_send_request_i[2])
        |=> !cancel_q[2])
        else $error("cancel on idle mailbox stored");
    a_success_finishes: assert property (@(posedge clk_sys_i) disable iff (srst_i || !clk_en_i)
        (tx_attempt_i.valid && tx_attempt_i.outcome == can_mbx_pkg::TX_OUT_SUCCESS
            && pending_q[tx_attempt_i.slot])
        |=> done_q[$past(tx_attempt_i.slot)] && success_q[$past(tx_attempt_i.slot)]
            && vacant[$past(tx_attempt_i.slot)])
        else $error("success did not complete mailbox");
    a_done_clear_all: assert property (@(posedge clk_sys_i) disable iff (srst_i || !clk_en_i)
        (wr_tx && wbits[2*`CMF_TX_SLOT_STRIDE + `CMF_TX_DONE_BIT]
            && !(tx_attempt_i.valid && tx_attempt_i.slot == 2'h2) && !cancel_q[2])
        |=> !done_q[2] && !success_q[2] && !lost_q[2] && !fault_q[2])
        else $error("done clear left status");
    a_cancel_gone_empty: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        !pending_q[0] |-> !cancel_q[0])
        else $error("cancel set on empty mailbox");
    a_bus_wait_once: assert property (@(posedge clk_sys_i) disable iff (srst_i || !clk_en_i)
        ((avs_read_i || avs_write_i) && !ack_q) |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
        else $error("wait state count wrong");
endmodule : can_mailbox_fifo_status

// File: test/can_bus_partner.sv
`timescale 1ns/1ps
// ----------------------------------------
// Far-side node model
// ----------------------------------------
module can_bus_partner (
    input wire logic clk_sys_i,
    output can_mbx_pkg::tx_attempt_s tx_attempt_o,
    output logic [2:0] tx_active_o,
    output logic [1:0] rx_store_o
);
    // Idle lines; no mailbox mid-frame until on_bus marks one
    initial begin
        tx_attempt_o = '0;
        tx_active_o = 3'h0;
        rx_store_o = 2'h0;
    end
    // One attempt report, released fields inverted afterwards
    task automatic attempt(input logic [1:0] slot, input can_mbx_pkg::tx_outcome_e res);
        tx_attempt_o <= '{1'b1, slot, res};
        @(posedge clk_sys_i);
        tx_attempt_o <= '{1'b0, ~slot, can_mbx_pkg::tx_outcome_e'(~res)};
        @(posedge clk_sys_i);
    endtask : attempt
    // One accepted frame into queue q
    task automatic store(input int q);
        rx_store_o[q] <= 1'b1;
        @(posedge clk_sys_i);
        rx_store_o <= 2'h0;
        @(posedge clk_sys_i);
    endtask : store
    // Mark mailboxes as currently on the bus
    task automatic on_bus(input logic [2:0] a);
        tx_active_o <= a;
        @(posedge clk_sys_i);
    endtask : on_bus
endmodule : can_bus_partner

// File: test/can_mailbox_fifo_status_tb.sv
`timescale 1ns/1ps
`include "can_mbx_params.svh"
module can_mailbox_fifo_status_tb;
    logic clk_sys_i = 1'b0;
    logic srst_i = 1'b1;
    logic [7:0] adr = 8'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic wait_o;
    logic [2:0] send = 3'h0;
    logic [2:0][28:0] ids = {29'h7, 29'h3, 29'h5};
    logic [2:0] active;
    logic [1:0] store;
    logic [1:0] irq;
    logic [31:0] got;
    logic en = 1'b1;
    logic [2:0] pnd;
    logic [2:0] cnc;
    logic [1:0] nxt;
    logic [1:0] rel;
    logic [1:0] ovw;
    int n_ovw = 0;
    int n_rel = 0;
    can_mbx_pkg::tx_attempt_s att;
    int n_fail = 0;
    int comparisons = 0;
    int cycles = 0;
    always #5 clk_sys_i = ~clk_sys_i;
    can_mailbox_fifo_status dut (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .clk_en_i(en),
        .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat),
        .avs_byteenable_i(4'hF), .avs_readdata_o(rdat), .avs_waitrequest_o(wait_o),
        .tx_send_request_i(send), .tx_active_i(active), .tx_attempt_i(att), .tx_slot_id_i(ids),
        .tx_pending_o(pnd), .tx_cancel_o(cnc), .tx_next_slot_o(nxt), .rx_store_i(store),
        .rx_release_o(rel), .rx_overwrite_o(ovw), .rx_pending_irq_o(irq));
    can_bus_partner nodes (.clk_sys_i(clk_sys_i), .tx_attempt_o(att), .tx_active_o(active),
        .rx_store_o(store));
    // ----------------------------------------
    // Bus tasks and checks
    // ----------------------------------------
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        adr <= a;
        wdat <= d;
        rd <= ~w;
        wr <= w;
        do @(posedge clk_sys_i); while (wait_o !== 1'b0);
        got = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk_sys_i);
    endtask : bus
    task automatic chk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
        bus(1'b0, a, 32'h0);
        comparisons++;
        if ((got & m) !== (exp & m)) begin
            n_fail++;
            $display("ERROR %0t reg %h read %h expected %h", $time, a, got, exp);
        end
    endtask : chk
    task automatic cmp(input logic [31:0] act, input logic [31:0] exp, input string what);
        comparisons++;
        if (act !== exp) begin
            n_fail++;
            $display("ERROR %0t %s %h expected %h", $time, what, act, exp);
        end
    endtask : cmp
    // Count release and overwrite pulses at each edge
    always @(posedge clk_sys_i) begin
        n_ovw <= n_ovw + $countones(ovw);
        n_rel <= n_rel + $countones(rel);
    end
    task automatic req(input logic [2:0] s);
        send <= s;
        @(posedge clk_sys_i);
        send <= 3'h0;
        @(posedge clk_sys_i);
    endtask : req
    task automatic complete_run;
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : complete_run
    // Hang guard
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 3000) begin
            n_fail++;
            complete_run;
        end
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (5) @(posedge clk_sys_i);
        srst_i <= 1'b0;
        chk(`CMF_TX_STATUS_OFS, `CMF_TX_STATUS_RST, 32'hFFFFFFFF);
        chk(`CMF_RXQ1_STATUS_OFS, 32'h0, 32'hFFFFFFFF);
        chk(8'h20, 32'h0, 32'hFFFFFFFF);
        req(3'h1);
        chk(`CMF_TX_STATUS_OFS, 32'h19000000, 32'hFF000000);
        req(3'h6);
        chk(`CMF_TX_STATUS_OFS, 32'h82000000, 32'hFF000000);
        cmp(nxt, 32'h2, "next slot");
        nodes.attempt(2'h2, can_mbx_pkg::TX_OUT_LOST_ARB);
        chk(`CMF_TX_STATUS_OFS, 32'h00040000, 32'h10060000);
        nodes.attempt(2'h2, can_mbx_pkg::TX_OUT_BUS_FAULT);
        chk(`CMF_TX_STATUS_OFS, 32'h00080000, 32'h100A0000);
        bus(1'b1, `CMF_TX_STATUS_OFS, 32'h00800000);
        chk(`CMF_TX_STATUS_OFS, 32'h32010000, 32'hFF830000);
        bus(1'b1, `CMF_TX_STATUS_OFS, 32'h00000000);
        chk(`CMF_TX_STATUS_OFS, 32'h00010000, 32'h00010000);
        bus(1'b1, `CMF_TX_STATUS_OFS, 32'h00010000);
        chk(`CMF_TX_STATUS_OFS, 32'h0, 32'h000F0000);
        bus(1'b1, `CMF_TX_STATUS_OFS, 32'h00800000);
        chk(`CMF_TX_STATUS_OFS, 32'h10000000, 32'h10FF0000);
        nodes.attempt(2'h0, can_mbx_pkg::TX_OUT_SUCCESS);
        chk(`CMF_TX_STATUS_OFS, 32'h14000003, 32'hFC0000FF);
        req(3'h1);
        chk(`CMF_TX_STATUS_OFS, 32'h0, 32'h04000001);
        nodes.on_bus(3'h1);
        bus(1'b1, `CMF_TX_STATUS_OFS, 32'h00000080);
        chk(`CMF_TX_STATUS_OFS, 32'h00000080, 32'h04000083);
        cmp({pnd, cnc}, 32'h19, "pending cancel");
        nodes.attempt(2'h0, can_mbx_pkg::TX_OUT_LOST_ARB);
        nodes.on_bus(3'h0);
        chk(`CMF_TX_STATUS_OFS, 32'h04000005, 32'h0400008F);
        bus(1'b1, `CMF_CTRL_OFS, 32'h8);
        req(3'h4);
        req(3'h1);
        chk(`CMF_TX_STATUS_OFS, 32'h20000000, 32'hFF000000);
        repeat (4) nodes.store(0);
        chk(`CMF_RXQ0_STATUS_OFS, 32'h1B, 32'hFFFFFFFF);
        bus(1'b1, `CMF_RXQ0_STATUS_OFS, 32'h20);
        chk(`CMF_RXQ0_STATUS_OFS, 32'h1A, 32'hFFFFFFFF);
        bus(1'b1, `CMF_RXQ0_STATUS_OFS, 32'h18);
        chk(`CMF_RXQ0_STATUS_OFS, 32'h02, 32'hFFFFFFFF);
        repeat (3) bus(1'b1, `CMF_RXQ0_STATUS_OFS, 32'h20);
        chk(`CMF_RXQ0_STATUS_OFS, 32'h0, 32'hFFFFFFFF);
        nodes.store(1);
        bus(1'b1, `CMF_CTRL_OFS, 32'h5);
        chk(`CMF_RXQ1_STATUS_OFS, 32'h01, 32'hFFFFFFFF);
        cmp(irq, 32'h2, "pending irq");
        // Frozen clock enable: this store must be lost
        en <= 1'b0;
        nodes.store(1);
        en <= 1'b1;
        chk(`CMF_RXQ1_STATUS_OFS, 32'h01, 32'hFFFFFFFF);
        // Locked queue: the overflowing message is discarded
        repeat (3) nodes.store(1);
        chk(`CMF_RXQ1_STATUS_OFS, 32'h1B, 32'hFFFFFFFF);
        cmp(n_ovw, 32'h1, "overwrites");
        cmp(n_rel, 32'h3, "releases");
        complete_run;
    end
endmodule : can_mailbox_fifo_status_tb
